// *** core/irq_consts.svh ***
// Register offsets, field positions and reset values of the interrupt request block
//
// Functional notes
// - Any source request but reserved group1 bit 6 sets its own group0 or group1 pending bit
// - Global enable forwards pending enabled request to core
// - Global enable clear: no core request, software polls
// - Group1 bit 7 holds two-wire serial pending
// - Group1 bit 6 reserved read-only, others RW
// - Group1 bit 5 holds port C pin 0
// - Group1 bit 4 shared by port B pins 3..0
// - Group1 bits 3..0 hold port A pin pairs
// - Group0 enable pairs encode off, low, nominal, high
// - Group1 enable pairs use the same encoding
// - Group0 high enables: PWM down to SPI order
// - Group0 low enables: same order as high
// - Group0 pending bits: PWM down to SPI order
// - Group1 enables share group1 pending bit layout
// - One master enable bit in control register
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define G0_PEND_ADDR 12'hfc0
`define G0_ENH_ADDR  12'hfc1
`define G0_ENL_ADDR  12'hfc2
`define G1_PEND_ADDR 12'hfc3
`define G1_ENH_ADDR  12'hfc4
`define G1_ENL_ADDR  12'hfc5
`define EVT_STAT_ADDR 12'hfc6
`define EVT_MASK_ADDR 12'hfc7
`define CTRL_ADDR    12'hfcf

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define G1_RSVD_BIT   6
`define G1_WR_MASK    8'hbf
`define CTRL_GIE_BIT  7
`define EVT_TAKEN_BIT 0
`define EVT_OVRN_BIT  1
`define REG8_RESET    8'h00
`define EVT_RESET     2'h0

`endif

// *** core/irq_pkg.sv ***
// Types shared by the interrupt request block
package irq_pkg;

	// Register bus request from software
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

	// Vectored request towards the core
	typedef struct packed {
		logic       valid;
		logic [3:0] vector;
		logic [1:0] level;
	} core_req_t;

	// Priority levels of an enable pair
	typedef enum logic [1:0] {
		PRIO_OFF,
		PRIO_LOW,
		PRIO_NOMINAL,
		PRIO_HIGH
	} prio_t;

	// High bit and low bit of an enable pair form the level
	function automatic prio_t prio_of(input logic hi, input logic lo);
		return prio_t'({hi, lo});
	endfunction : prio_of

endpackage : irq_pkg

// *** core/irq_prio_pick.sv ***
// Priority picker choosing the pending enabled source of highest level
`timescale 1ns/10ps
`default_nettype none

module irq_prio_pick #(
	parameter int NSRC = 16,
	parameter int IDXW = 4
) (
	// Source state
	input  wire logic [NSRC-1:0] pending,
	input  wire logic [NSRC-1:0] en_high,
	input  wire logic [NSRC-1:0] en_low,
	// Winner
	output irq_pkg::core_req_t   pick
);

	// Strict compare keeps the lowest index on a tie
	always_comb begin
		logic [1:0] best;
		logic [1:0] lv;
		best = 2'h0;
		lv   = 2'h0;
		pick = '0;
		for (int i = 0; i < NSRC; i++) begin
			lv = irq_pkg::prio_of(en_high[i], en_low[i]);
			if (pending[i] && (lv > best)) begin
				best        = lv;
				pick.valid  = 1'b1;
				pick.vector = IDXW'(i);
				pick.level  = lv;
			end
		end
	end

endmodule : irq_prio_pick

`default_nettype wire

// *** core/irq_ctrl.sv ***
// Interrupt request, priority enable and master enable block
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "irq_consts.svh"

module irq_ctrl (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	// Register port
	input  wire irq_pkg::bus_req_t bus_in,
	output logic [7:0]             rd_data,
	// Group0: pwm, fault, converter, comparator, timer0, rx, tx, spi
	input  wire logic [7:0]        group0_src,
	// Group1: twowire, reserved, portc0, portb, porta pairs
	input  wire logic [7:0]        group1_src,
	// Core side
	input  wire logic              core_ack,
	output var irq_pkg::core_req_t core_req,
	// Event interrupt
	output logic                   irq
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] group0_pending_requests;
	logic [7:0] group0_enable_high;
	logic [7:0] group0_enable_low;
	logic [7:0] group1_pending_requests;
	logic [7:0] group1_enable_high;
	logic [7:0] group1_enable_low;
	logic       global_irq_enable;
	logic [1:0] evt_status;
	logic [1:0] evt_mask;

	logic [7:0]         next_g0_pend;
	logic [7:0]         next_g1_pend;
	logic [1:0]         next_evt_status;
	logic [15:0]        ack_clr;
	logic [15:0]        pending_all;
	logic [15:0]        en_high_all;
	logic [15:0]        en_low_all;
	logic [1:0]         events;
	irq_pkg::core_req_t pick;

	// Write hit on one register address
	function automatic logic wr_hit(input irq_pkg::bus_req_t b, input logic [11:0] a);
		return b.wr && (b.addr == a);
	endfunction : wr_hit

	// ----------------------------------------------------------------
	// Source map
	// ----------------------------------------------------------------
	// Bit 7 twowire, 5 portc pin0, 4 portb pins 3..0, 3..0 porta pairs
	// Group0 bit 7 pwm down to bit 0 spi; enables share the layout
	assign pending_all = {group1_pending_requests, group0_pending_requests};
	assign en_high_all = {group1_enable_high, group0_enable_high};
	assign en_low_all  = {group1_enable_low, group0_enable_low};

	// Ack clears exactly the vector it names
	assign ack_clr = core_ack ? 16'(16'h0001 << core_req.vector) : 16'h0000;

	// ----------------------------------------------------------------
	// Pending requests
	// ----------------------------------------------------------------
	// A source edge in the clearing cycle still lands: set wins
	always_comb begin
		next_g0_pend = wr_hit(bus_in, `G0_PEND_ADDR) ? bus_in.wdata : group0_pending_requests;
		next_g0_pend = (next_g0_pend & ~ack_clr[7:0]) | group0_src;
		next_g1_pend = wr_hit(bus_in, `G1_PEND_ADDR) ? bus_in.wdata : group1_pending_requests;
		next_g1_pend = (next_g1_pend & ~ack_clr[15:8]) | group1_src;
		next_g1_pend = next_g1_pend & `G1_WR_MASK;
	end

	// Pending registers
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			group0_pending_requests <= `REG8_RESET;
			group1_pending_requests <= `REG8_RESET;
		end else begin
			group0_pending_requests <= next_g0_pend;
			group1_pending_requests <= next_g1_pend;
		end
	end

	// ----------------------------------------------------------------
	// Priority enables
	// ----------------------------------------------------------------
	// Group1 reserved bit stays zero in both enables
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			group0_enable_high <= `REG8_RESET;
			group0_enable_low  <= `REG8_RESET;
			group1_enable_high <= `REG8_RESET;
			group1_enable_low  <= `REG8_RESET;
		end else begin
			if (wr_hit(bus_in, `G0_ENH_ADDR)) begin
				group0_enable_high <= bus_in.wdata;
			end
			if (wr_hit(bus_in, `G0_ENL_ADDR)) begin
				group0_enable_low <= bus_in.wdata;
			end
			if (wr_hit(bus_in, `G1_ENH_ADDR)) begin
				group1_enable_high <= bus_in.wdata & `G1_WR_MASK;
			end
			if (wr_hit(bus_in, `G1_ENL_ADDR)) begin
				group1_enable_low <= bus_in.wdata & `G1_WR_MASK;
			end
		end
	end

	// ----------------------------------------------------------------
	// Master enable
	// ----------------------------------------------------------------
	// Taking a vector drops the enable so the handler is not re-entered
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			global_irq_enable <= 1'b0;
		end else if (wr_hit(bus_in, `CTRL_ADDR)) begin
			global_irq_enable <= bus_in.wdata[`CTRL_GIE_BIT];
		end else if (core_ack) begin
			global_irq_enable <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Vector towards the core
	// ----------------------------------------------------------------
	irq_prio_pick #(
		.NSRC (16),
		.IDXW (4)
	) u_pick (
		.pending (pending_all),
		.en_high (en_high_all),
		.en_low  (en_low_all),
		.pick    (pick)
	);

	// Registered request; polled mode keeps it quiet
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			core_req <= '0;
		end else if (global_irq_enable && !core_ack) begin
			core_req <= pick;
		end else begin
			core_req <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Event status, mask and interrupt line
	// ----------------------------------------------------------------
	// Taken vector, and a request landing on a bit already pending
	assign events[`EVT_TAKEN_BIT] = core_ack;
	assign events[`EVT_OVRN_BIT]  = |({group1_src, group0_src} & pending_all);

	// Write one clears; a new event in the same cycle wins
	always_comb begin
		next_evt_status = evt_status;
		if (wr_hit(bus_in, `EVT_STAT_ADDR)) begin
			next_evt_status = evt_status & ~bus_in.wdata[1:0];
		end
		next_evt_status = next_evt_status | events;
	end

	// Status and mask registers
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			evt_status <= `EVT_RESET;
			evt_mask   <= `EVT_RESET;
		end else begin
			evt_status <= next_evt_status;
			if (wr_hit(bus_in, `EVT_MASK_ADDR)) begin
				evt_mask <= bus_in.wdata[1:0];
			end
		end
	end

	// Level line, one cycle behind the status
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(evt_status & evt_mask);
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Data stands one cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rd_data <= `REG8_RESET;
		end else if (bus_in.rd) begin
			case (bus_in.addr)
				`G0_PEND_ADDR:  rd_data <= group0_pending_requests;
				`G0_ENH_ADDR:   rd_data <= group0_enable_high;
				`G0_ENL_ADDR:   rd_data <= group0_enable_low;
				`G1_PEND_ADDR:  rd_data <= group1_pending_requests;
				`G1_ENH_ADDR:   rd_data <= group1_enable_high;
				`G1_ENL_ADDR:   rd_data <= group1_enable_low;
				`EVT_STAT_ADDR: rd_data <= {6'h00, evt_status};
				`EVT_MASK_ADDR: rd_data <= {6'h00, evt_mask};
				`CTRL_ADDR:     rd_data <= {global_irq_enable, 7'h00};
				default:        rd_data <= `REG8_RESET;
			endcase
		end else begin
			rd_data <= `REG8_RESET;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	property p_src_sets_pending;
		(group0_src != 8'h00) |=> ((group0_pending_requests & $past(group0_src)) == $past(group0_src));
	endproperty
	a_src_sets_pending: assert property (p_src_sets_pending)
		else $error("group0 request did not set pending");

	property p_twowire_pending;
		group1_src[7] |=> group1_pending_requests[7] [*1] ##1 1'b1;
	endproperty
	a_twowire_pending: assert property (p_twowire_pending)
		else $error("twowire request not pending");

	property p_vector_forwarded;
		(global_irq_enable && pick.valid && !core_ack)
			|=> (core_req.valid && core_req.vector == $past(pick.vector));
	endproperty
	a_vector_forwarded: assert property (p_vector_forwarded)
		else $error("enabled request not forwarded");

	property p_polled_quiet;
		!global_irq_enable |=> !core_req.valid;
	endproperty
	a_polled_quiet: assert property (p_polled_quiet)
		else $error("core interrupted while disabled");

	property p_reserved_zero;
		!group1_pending_requests[6] && !group1_enable_high[6] && !group1_enable_low[6];
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bit set");

	property p_level_encoding;
		pick.valid |-> (pick.level == {en_high_all[pick.vector], en_low_all[pick.vector]}
			&& pick.level != 2'h0 && pending_all[pick.vector]);
	endproperty
	a_level_encoding: assert property (p_level_encoding)
		else $error("picked level does not match enable pair");

	property p_highest_wins;
		|(pending_all & en_high_all & en_low_all) |-> (pick.valid && pick.level == 2'h3);
	endproperty
	a_highest_wins: assert property (p_highest_wins)
		else $error("high level request not chosen");

	property p_ack_drops_enable;
		(core_ack && !wr_hit(bus_in, `CTRL_ADDR)) |=> (!global_irq_enable ##1 !core_req.valid);
	endproperty
	a_ack_drops_enable: assert property (p_ack_drops_enable)
		else $error("master enable kept after ack");

	property p_write_zero_clears;
		(wr_hit(bus_in, `G0_PEND_ADDR) && bus_in.wdata == 8'h00 && group0_src == 8'h00)
			|=> (group0_pending_requests == 8'h00);
	endproperty
	a_write_zero_clears: assert property (p_write_zero_clears)
		else $error("write of zero did not clear pending");

	property p_read_pending;
		(bus_in.rd && bus_in.addr == `G1_PEND_ADDR) |=> (rd_data == $past(group1_pending_requests));
	endproperty
	a_read_pending: assert property (p_read_pending)
		else $error("polled read wrong");

	// Port sources share the set-wins path of the serial bus bit
	property p_port_sets_pending;
		((group1_src & 8'h3f) != 8'h00)
			|=> ((group1_pending_requests & $past(group1_src) & 8'h3f)
				== ($past(group1_src) & 8'h3f));
	endproperty
	a_port_sets_pending: assert property (p_port_sets_pending)
		else $error("port request did not set pending");

	property p_enable_high_write;
		wr_hit(bus_in, `G0_ENH_ADDR) |=> (group0_enable_high == $past(bus_in.wdata));
	endproperty
	a_enable_high_write: assert property (p_enable_high_write)
		else $error("group0 high enable write lost");

	property p_enable_low_write;
		wr_hit(bus_in, `G0_ENL_ADDR) |=> (group0_enable_low == $past(bus_in.wdata));
	endproperty
	a_enable_low_write: assert property (p_enable_low_write)
		else $error("group0 low enable write lost");

	// Reserved position must drop out of a group1 enable write
	property p_group1_enable_write;
		wr_hit(bus_in, `G1_ENH_ADDR)
			|=> (group1_enable_high == ($past(bus_in.wdata) & `G1_WR_MASK));
	endproperty
	a_group1_enable_write: assert property (p_group1_enable_write)
		else $error("group1 high enable write wrong");

	// First edge after release still shows the reset values
	property p_reset_clears;
		!$past(rst_b) |-> ((group0_pending_requests | group1_pending_requests) == `REG8_RESET
			&& (group0_enable_high | group0_enable_low) == `REG8_RESET
			&& (group1_enable_high | group1_enable_low) == `REG8_RESET
			&& !global_irq_enable);
	endproperty
	a_reset_clears: assert property (p_reset_clears)
		else $error("register not zero after reset");

	c_vector_taken: cover property (core_req.valid ##1 core_ack);
	c_overrun: cover property (events[`EVT_OVRN_BIT] ##2 irq);
	c_high_pick: cover property (pick.valid && pick.level == 2'h3 && global_irq_enable);
	c_polled_request: cover property (!global_irq_enable && group1_pending_requests[7]);
	c_tie_break: cover property (pick.valid && pending_all[15] && pending_all[5]);

endmodule : irq_ctrl

`default_nettype wire

// *** testbench/core_model.sv ***
// Processor core model that takes vectored requests from the block
`timescale 1ns/10ps
`default_nettype none

module core_model (
	// Clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst_b,
	// Request from the block
	input  wire irq_pkg::core_req_t core_req,
	output logic                    core_ack,
	// Bench control and record
	input  wire logic               ack_en,
	input  wire logic [3:0]         ack_wait,
	output logic [7:0]              taken
);
	logic [3:0] cnt;

	// Acknowledge only a request on offer, after a chosen wait, so slow cores are covered too
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			core_ack <= 1'b0;
			cnt      <= 4'h0;
			taken    <= 8'h00;
		end else if (core_ack) begin
			core_ack <= 1'b0; // One-cycle acknowledge pulse
			cnt      <= 4'h0;
		end else if (core_req.valid && ack_en) begin
			if (cnt == ack_wait) begin
				core_ack <= 1'b1;
				taken    <= taken + 8'h01;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end else begin
			cnt <= 4'h0;
		end
	end

endmodule : core_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the interrupt request block
`timescale 1ns/10ps
`default_nettype none
`include "irq_consts.svh"

module tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic               sys_clk = 1'b0;
	logic               rst_b = 1'b0;
	irq_pkg::bus_req_t  bus = '0;
	logic [7:0]         rd_data;
	logic [7:0]         g0_src = 8'h00;
	logic [7:0]         g1_src = 8'h00;
	logic               core_ack;
	irq_pkg::core_req_t core_req;
	logic               irq;
	logic               ack_en = 1'b0;
	logic [3:0]         ack_wait = 4'h0;
	logic [7:0]         taken;
	logic [7:0]         m;
	logic [1:0]         lvl;
	int                 miscompares = 0;
	int                 compares = 0;
	int                 i;
	logic [3:0]         pvec [3] = '{4'h5, 4'hf, 4'h0};
	logic [1:0]         plvl [3] = '{2'h3, 2'h3, 2'h1};

	// 100 ns clock
	always #50 sys_clk = ~sys_clk;

	irq_ctrl u_dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .bus_in(bus), .rd_data(rd_data),
		.group0_src(g0_src), .group1_src(g1_src), .core_ack(core_ack),
		.core_req(core_req), .irq(irq)
	);

	core_model u_core (
		.sys_clk(sys_clk), .rst_b(rst_b), .core_req(core_req), .core_ack(core_ack),
		.ack_en(ack_en), .ack_wait(ack_wait), .taken(taken)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task wrap_up;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
			miscompares++;
		end
	endtask : check

	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus <= '0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task rd_chk(input logic [11:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus <= '0;
		#1;
		check(rd_data, e);
	endtask : rd_chk

	task pulse(input logic [7:0] a0, input logic [7:0] a1);
		@(posedge sys_clk);
		g0_src <= a0;
		g1_src <= a1;
		@(posedge sys_clk);
		g0_src <= 8'h00;
		g1_src <= 8'h00;
	endtask : pulse

	// Bounded wait for the offered request to reach a level
	task wait_req(input logic want);
		int n;
		n = 0;
		#1;
		while (core_req.valid !== want && n < 40) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (core_req.valid !== want) begin
			$display("MISMATCH %0t wait for request timed out", $time);
			miscompares++;
			wrap_up();
		end
	endtask : wait_req

	task take(input logic [3:0] v, input logic [1:0] l);
		wr(`CTRL_ADDR, 8'h80);
		wait_req(1'b1);
		check({4'h0, core_req.vector}, {4'h0, v});
		check({6'h00, core_req.level}, {6'h00, l});
		ack_en <= 1'b1;
		wait_req(1'b0);
		ack_en <= 1'b0;
	endtask : take

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		// Every place from fc0 to fcf, mapped or not, reads zero after reset
		for (i = 0; i < 16; i++) rd_chk(12'hfc0 + 12'(i), 8'h00);
		check({7'h00, core_req.valid}, 8'h00);
		$display("test reset done");
		// Access kinds; reserved group1 bit stays zero
		wr(`G0_ENH_ADDR, 8'hff);
		rd_chk(`G0_ENH_ADDR, 8'hff);
		wr(`G0_ENL_ADDR, 8'h5a);
		rd_chk(`G0_ENL_ADDR, 8'h5a);
		wr(`G1_ENH_ADDR, 8'hff);
		rd_chk(`G1_ENH_ADDR, 8'hbf);
		wr(`G1_ENL_ADDR, 8'hff);
		rd_chk(`G1_ENL_ADDR, 8'hbf);
		wr(`CTRL_ADDR, 8'hff);
		rd_chk(`CTRL_ADDR, 8'h80);
		wr(`CTRL_ADDR, 8'h00);
		wr(12'hfc8, 8'hff);
		rd_chk(12'hfc8, 8'h00);
		wr(`G1_PEND_ADDR, 8'hff);
		wr(`G0_PEND_ADDR, 8'ha5);
		rd_chk(`G1_PEND_ADDR, 8'hbf);
		rd_chk(`G0_PEND_ADDR, 8'ha5);
		check({7'h00, core_req.valid}, 8'h00);
		wr(`G1_PEND_ADDR, 8'h00);
		wr(`G0_PEND_ADDR, 8'h00);
		rd_chk(`G1_PEND_ADDR, 8'h00);
		$display("test access done");
		// Polled: each source but reserved group1 bit 6 sets its own bit, nothing reaches the core
		for (i = 0; i < 16; i++) begin
			m = 8'h01 << (i % 8);
			pulse(i < 8 ? m : 8'h00, i < 8 ? 8'h00 : m);
			rd_chk(i < 8 ? `G0_PEND_ADDR : `G1_PEND_ADDR, i == 14 ? 8'h00 : m);
			check({7'h00, core_req.valid}, 8'h00);
			wr(i < 8 ? `G0_PEND_ADDR : `G1_PEND_ADDR, 8'h00);
		end
		check(taken, 8'h00);
		$display("test polled done");
		// Vectored: every source but reserved group1 bit 6 at a level, prompt and slow acknowledge
		for (i = 0; i < 16; i++) begin
			if (i != 14) begin
				m = 8'h01 << (i % 8);
				lvl = 2'(i % 3 + 1);
				ack_wait <= 4'(i % 4);
				wr(`G0_ENH_ADDR, (i < 8 && lvl[1]) ? m : 8'h00);
				wr(`G0_ENL_ADDR, (i < 8 && lvl[0]) ? m : 8'h00);
				wr(`G1_ENH_ADDR, (i >= 8 && lvl[1]) ? m : 8'h00);
				wr(`G1_ENL_ADDR, (i >= 8 && lvl[0]) ? m : 8'h00);
				pulse(i < 8 ? m : 8'h00, i < 8 ? 8'h00 : m);
				take(4'(i), lvl);
				rd_chk(i < 8 ? `G0_PEND_ADDR : `G1_PEND_ADDR, 8'h00);
				rd_chk(`CTRL_ADDR, 8'h00);
			end
		end
		check(taken, 8'h0f);
		$display("test vectored done");
		// Highest level first, lowest index breaks the tie
		wr(`G0_ENH_ADDR, 8'h20);
		wr(`G0_ENL_ADDR, 8'h21);
		wr(`G1_ENH_ADDR, 8'h80);
		wr(`G1_ENL_ADDR, 8'h80);
		pulse(8'h21, 8'h80);
		for (i = 0; i < 3; i++) take(pvec[i], plvl[i]);
		rd_chk(`G1_PEND_ADDR, 8'h00);
		$display("test priority done");
		// Event status, mask and interrupt line
		rd_chk(`EVT_STAT_ADDR, 8'h01);
		check({7'h00, irq}, 8'h00);
		wr(`EVT_MASK_ADDR, 8'h01);
		repeat (2) @(posedge sys_clk);
		#1;
		check({7'h00, irq}, 8'h01);
		wr(`EVT_STAT_ADDR, 8'h01);
		repeat (2) @(posedge sys_clk);
		#1;
		check({7'h00, irq}, 8'h00);
		pulse(8'h02, 8'h00);
		pulse(8'h02, 8'h00);
		rd_chk(`EVT_STAT_ADDR, 8'h02);
		check({7'h00, irq}, 8'h00);
		wr(`EVT_MASK_ADDR, 8'h02);
		repeat (2) @(posedge sys_clk);
		#1;
		check({7'h00, irq}, 8'h01);
		$display("test events done");
		wrap_up();
	end

endmodule : tb_top
`default_nettype wire
